// ==== hdl/ors_host.sv ====
/*
 Host end: sequences supplies, the display reset pin and the serial
 command stream for power-up, power-down and noise recovery.
 Assumes the display end samples the link on the same mclk.
*/
`timescale 1ns/100ps
`include "ors_cfg.svh"
`default_nettype none
module ors_host #(
	parameter int SETTLE_CYCLES = `ORS_SETTLE_CYC // Panel settle wait
) (
	input wire logic mclk, // System clock
	input wire logic nrst, // Async reset, low
	ors_link_if.host link, // Pins to the display
	input wire logic powerUp, // Pulse: start power-up
	input wire logic powerDown, // Pulse: start power-down
	input wire logic recover, // Pulse: reset and reinit
	output logic busy, // Sequence in progress
	output logic running // Display up and on
);
	import ors_pkg::*;

	ors_host_state_t state; // Sequencer state
	logic [31:0] waitCnt; // Reset and settle timer
	logic [10:0] idx; // Byte index in a step
	logic txActive; // Byte being shifted
	logic [1:0] divCnt; // Serial clock phase
	logic [2:0] bitCnt; // Bits sent
	ors_byte_t shReg; // Outgoing byte
	ors_host_state_t next_state;
	logic [31:0] next_waitCnt;
	logic [10:0] next_idx;
	logic next_txActive;
	logic [1:0] next_divCnt;
	logic [2:0] next_bitCnt;
	ors_byte_t next_shReg;
	logic next_rst, next_vdd, next_booster_supply, next_vcc;
	logic next_cs, next_dc, next_sclk, next_sdin;
	logic [10:0] reqLen; // Bytes in this step
	ors_byte_t reqByte; // Byte to send next
	logic reqDc; // Data flag of that byte
	logic sending; // Step sends bytes

	// Initialisation commands in order
	function automatic ors_byte_t initByte(input logic [10:0] i);
		case (i[3:0])
			4'h0: initByte = `ORS_CMD_MUX;
			4'h1: initByte = {2'h0, `ORS_RST_MUX};
			4'h2: initByte = {2'h1, `ORS_RST_START};
			4'h3: initByte = `ORS_CMD_SEG_NORM;
			4'h4: initByte = `ORS_CMD_COM_NORM;
			4'h5: initByte = `ORS_CMD_CONTRAST;
			4'h6: initByte = `ORS_RST_CONTRAST;
			4'h7: initByte = `ORS_CMD_SHOW_RAM;
			4'h8: initByte = `ORS_CMD_NORMAL;
			4'h9: initByte = 8'h00;
			default: initByte = 8'h10;
		endcase
	endfunction

	// Sequencer and serial shifter
	always_comb begin
		next_state = state;
		next_waitCnt = waitCnt;
		next_idx = idx;
		next_txActive = txActive;
		next_divCnt = divCnt;
		next_bitCnt = bitCnt;
		next_shReg = shReg;
		next_rst = link.resetPinLowActive;
		next_vdd = link.logicSupplyEn;
		next_booster_supply = link.boosterSupplyEn;
		next_vcc = link.panelSupplyEn;
		next_cs = link.csN;
		next_dc = link.dcN;
		next_sclk = link.sclk;
		next_sdin = link.sdin;
		sending = 1'b1;
		reqLen = 11'h001;
		reqDc = 1'b0;
		reqByte = `ORS_CMD_DISP_OFF;
		case (state)
			H_INIT: begin
				reqLen = `ORS_INIT_LEN;
				reqByte = initByte(idx);
			end
			H_CLEAR: begin
				// Zero data over the whole memory
				reqLen = `ORS_CLEAR_LEN;
				reqByte = 8'h00;
				reqDc = 1'b1;
			end
			H_SEND_ON: reqByte = `ORS_CMD_DISP_ON;
			H_SEND_OFF, H_DN_OFF: reqByte = `ORS_CMD_DISP_OFF;
			default: sending = 1'b0;
		endcase
		if (txActive) begin
			next_divCnt = divCnt + 2'h1;
			case (divCnt)
				2'h0: begin
					next_sclk = 1'b0;
					next_sdin = shReg[7];
				end
				2'h2: next_sclk = 1'b1;
				2'h3: begin
					next_shReg = {shReg[6:0], 1'b0};
					next_bitCnt = bitCnt + 3'h1;
					if (bitCnt == 3'h7) begin
						next_txActive = 1'b0;
						next_cs = 1'b1;
						next_idx = idx + 11'h001;
					end
				end
				default: next_sclk = link.sclk;
			endcase
		end else if (sending && idx < reqLen) begin
			next_txActive = 1'b1;
			next_shReg = reqByte;
			next_dc = reqDc;
			next_cs = 1'b0;
			next_divCnt = 2'h0;
			next_bitCnt = 3'h0;
		end
		case (state)
			H_OFF: begin
				if (powerUp) begin
					next_vdd = 1'b1;
					next_booster_supply = 1'b1;
					next_rst = 1'b0;
					next_waitCnt = 32'h0;
					next_state = H_RST_LOW;
				end
			end
			H_RST_LOW: begin
				next_waitCnt = waitCnt + 32'h1;
				if (waitCnt == 32'(`ORS_RES_LOW_CYC - 1)) begin
					next_rst = 1'b1;
					next_state = H_SEND_OFF;
				end
			end
			H_SEND_OFF, H_INIT: begin
				if (!txActive && idx == reqLen) begin
					next_idx = 11'h000;
					next_state = (state == H_SEND_OFF) ? H_INIT : H_CLEAR;
				end
			end
			H_CLEAR: begin
				if (!txActive && idx == reqLen) begin
					next_vcc = 1'b1;
					next_idx = 11'h000;
					next_waitCnt = 32'h0;
					next_state = H_VCC_WAIT;
				end
			end
			H_VCC_WAIT: begin
				next_waitCnt = waitCnt + 32'h1;
				if (waitCnt == 32'(SETTLE_CYCLES - 1)) begin
					next_state = H_SEND_ON;
				end
			end
			H_SEND_ON: begin
				if (!txActive && idx == reqLen) begin
					next_idx = 11'h000;
					next_state = H_RUN;
				end
			end
			H_RUN: begin
				if (powerDown) begin
					next_state = H_DN_OFF;
				end else if (recover) begin
					next_rst = 1'b0;
					next_waitCnt = 32'h0;
					next_state = H_RST_LOW;
				end
			end
			H_DN_OFF: begin
				if (!txActive && idx == reqLen) begin
					next_vcc = 1'b0;
					next_booster_supply = 1'b0;
					next_idx = 11'h000;
					next_waitCnt = 32'h0;
					next_state = H_DN_WAIT;
				end
			end
			H_DN_WAIT: begin
				next_waitCnt = waitCnt + 32'h1;
				if (waitCnt == 32'(SETTLE_CYCLES - 1)) begin
					next_vdd = 1'b0;
					next_rst = 1'b0;
					next_state = H_OFF;
				end
			end
			default: next_state = H_OFF;
		endcase
	end

	// State and pin registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= H_OFF;
			waitCnt <= 32'h0;
			idx <= 11'h000;
			txActive <= 1'b0;
			divCnt <= 2'h0;
			bitCnt <= 3'h0;
			shReg <= 8'h00;
			link.resetPinLowActive <= 1'b0;
			link.logicSupplyEn <= 1'b0;
			link.boosterSupplyEn <= 1'b0;
			link.panelSupplyEn <= 1'b0;
			{link.interfaceSelectBit2, link.interfaceSelectBit1,
				link.interfaceSelectBit0} <= `ORS_SEL_SPI4;
			link.csN <= 1'b1;
			link.dcN <= 1'b0;
			link.sclk <= 1'b0;
			link.sdin <= 1'b0;
			busy <= 1'b0;
			running <= 1'b0;
		end else begin
			state <= next_state;
			waitCnt <= next_waitCnt;
			idx <= next_idx;
			txActive <= next_txActive;
			divCnt <= next_divCnt;
			bitCnt <= next_bitCnt;
			shReg <= next_shReg;
			link.resetPinLowActive <= next_rst;
			link.logicSupplyEn <= next_vdd;
			link.boosterSupplyEn <= next_booster_supply;
			link.panelSupplyEn <= next_vcc;
			{link.interfaceSelectBit2, link.interfaceSelectBit1,
				link.interfaceSelectBit0} <= `ORS_SEL_SPI4;
			link.csN <= next_cs;
			link.dcN <= next_dc;
			link.sclk <= next_sclk;
			link.sdin <= next_sdin;
			busy <= next_state != H_OFF && next_state != H_RUN;
			running <= next_state == H_RUN;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/ors_cfg.svh ====
/*
 Constants for the display reset and supply sequencing ends: reset
 values, command codes, interface select code and timing counts.
 Assumes a 40 MHz mclk shared by both ends.
*/
// Summary of operation
// - Reset pin low: display off, 128x64 mode
// - Reset: normal segment and row mapping
// - Reset clears serial interface shift register
// - Reset: display start line at zero
// - Reset: column address counter at zero
// - Reset: normal row output scan direction
// - Reset: contrast register loads 7f
// - Reset: normal display, as command a4
// - Host powers up logic, off, init, clear, panel
// - Host waits 100 ms before display on
// - Host power-down: off, panel, wait, logic
// - Logic supply never removed before panel supplies
// - Host resets display to recover from noise
// - Host uses interface chosen by select pins
`ifndef ORS_CFG_SVH
`define ORS_CFG_SVH

// Clock and timing
`define ORS_MCLK_NS 25
`define ORS_SETTLE_MS 100
`define ORS_SETTLE_CYC (`ORS_SETTLE_MS * 1000000 / `ORS_MCLK_NS)
`define ORS_RES_LOW_NS 3000
`define ORS_RES_LOW_CYC ((`ORS_RES_LOW_NS + `ORS_MCLK_NS - 1) / `ORS_MCLK_NS)

// Interface select code for the 4-wire serial link
`define ORS_SEL_SPI4 3'h0

// Reset values and mux ratio floor of the display state
`define ORS_RST_CONTRAST 8'h7f
`define ORS_RST_MUX 6'h3f
`define ORS_RST_START 6'h00
`define ORS_RST_COL 7'h00
`define ORS_MUX_MIN 6'h0f

// Command codes
`define ORS_CMD_DISP_OFF 8'hae
`define ORS_CMD_DISP_ON 8'haf
`define ORS_CMD_SHOW_RAM 8'ha4
`define ORS_CMD_ALL_LIT 8'ha5
`define ORS_CMD_NORMAL 8'ha6
`define ORS_CMD_INVERSE 8'ha7
`define ORS_CMD_SEG_NORM 8'ha0
`define ORS_CMD_SEG_REMAP 8'ha1
`define ORS_CMD_COM_NORM 8'hc0
`define ORS_CMD_COM_REV 8'hc8
`define ORS_CMD_CONTRAST 8'h81
`define ORS_CMD_MUX 8'ha8

// Host sequence lengths in bytes
`define ORS_INIT_LEN 11'h00b
`define ORS_CLEAR_LEN 11'h400

`endif

// ==== hdl/ors_pkg.sv ====
/*
 Types shared by both ends of the display sequencing link.
 Assumes ors_cfg.svh for all numeric constants.
*/
package ors_pkg;
	// One command or data byte
	typedef logic [7:0] ors_byte_t;

	// Display end command parser states
	typedef enum logic [3:0] {
		D_HOLD = 4'h1,
		D_IDLE = 4'h2,
		D_ARG_CONTRAST = 4'h4,
		D_ARG_MUX = 4'h8
	} ors_dev_state_t;

	// Host sequencer states
	typedef enum logic [9:0] {
		H_OFF = 10'h001,
		H_RST_LOW = 10'h002,
		H_SEND_OFF = 10'h004,
		H_INIT = 10'h008,
		H_CLEAR = 10'h010,
		H_VCC_WAIT = 10'h020,
		H_SEND_ON = 10'h040,
		H_RUN = 10'h080,
		H_DN_OFF = 10'h100,
		H_DN_WAIT = 10'h200
	} ors_host_state_t;
endpackage

// ==== hdl/ors_link_if.sv ====
/*
 Pins between the host and the display: reset, supply enables,
 interface select straps and the 4-wire serial command link.
 Assumes both ends run on the same mclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface ors_link_if;
	logic resetPinLowActive; // Display reset, low active
	logic logicSupplyEn; // Logic supply on
	logic boosterSupplyEn; // Booster supply on
	logic panelSupplyEn; // Panel high voltage on
	logic interfaceSelectBit0; // Select strap bit 0
	logic interfaceSelectBit1; // Select strap bit 1
	logic interfaceSelectBit2; // Select strap bit 2
	logic csN; // Chip select, low active
	logic dcN; // Low command, high data
	logic sclk; // Serial clock
	logic sdin; // Serial data, msb first

	modport host (
		output resetPinLowActive, logicSupplyEn, boosterSupplyEn,
		output panelSupplyEn, interfaceSelectBit0, interfaceSelectBit1,
		output interfaceSelectBit2, csN, dcN, sclk, sdin
	);
	modport device (
		input resetPinLowActive, logicSupplyEn, boosterSupplyEn,
		input panelSupplyEn, interfaceSelectBit0, interfaceSelectBit1,
		input interfaceSelectBit2, csN, dcN, sclk, sdin
	);
endinterface
`default_nettype wire

// ==== hdl/ors_serial_rx.sv ====
/*
 Serial byte receiver of the display end. Samples sdin on each
 rising sclk while chip select is low. Assumes link pins are
 synchronous to mclk and sclk is at most a quarter of mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module ors_serial_rx (
	input wire logic mclk, // System clock
	input wire logic nrst, // Async reset, low
	input wire logic clear, // Drop partial byte
	input wire logic csN, // Chip select, low active
	input wire logic sclk, // Serial clock
	input wire logic sdin, // Serial data
	input wire logic dcN, // Command or data flag
	output logic byteValid, // One-cycle byte strobe
	output ors_pkg::ors_byte_t byteData, // Received byte
	output logic byteIsData // Byte is display data
);
	import ors_pkg::*;

	logic sclkPrev; // Previous sclk for edge detect
	logic [2:0] bitCnt; // Bits held in shifter
	ors_byte_t shifter; // Partial byte
	logic next_sclkPrev;
	logic [2:0] next_bitCnt;
	ors_byte_t next_shifter;
	logic next_byteValid;
	ors_byte_t next_byteData;
	logic next_byteIsData;

	// Shift on rising sclk, emit after eighth bit
	always_comb begin
		next_sclkPrev = sclk;
		next_bitCnt = bitCnt;
		next_shifter = shifter;
		next_byteValid = 1'b0;
		next_byteData = byteData;
		next_byteIsData = byteIsData;
		if (clear || csN) begin
			// Deselect also drops a partial byte so framing recovers
			next_bitCnt = 3'h0;
			next_shifter = 8'h00;
		end else if (sclk && !sclkPrev) begin
			next_shifter = {shifter[6:0], sdin};
			next_bitCnt = bitCnt + 3'h1;
			if (bitCnt == 3'h7) begin
				next_byteValid = 1'b1;
				next_byteData = {shifter[6:0], sdin};
				next_byteIsData = dcN;
			end
		end
	end

	// State registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclkPrev <= 1'b0;
			bitCnt <= 3'h0;
			shifter <= 8'h00;
			byteValid <= 1'b0;
			byteData <= 8'h00;
			byteIsData <= 1'b0;
		end else begin
			sclkPrev <= next_sclkPrev;
			bitCnt <= next_bitCnt;
			shifter <= next_shifter;
			byteValid <= next_byteValid;
			byteData <= next_byteData;
			byteIsData <= next_byteIsData;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/ors_device.sv ====
/*
 Display end: holds the display state at its reset values while the
 reset pin is low, then parses serial commands and data bytes.
 Assumes the host drives the link pins synchronously to mclk and
 keeps its own power and command ordering.
*/
`timescale 1ns/100ps
`include "ors_cfg.svh"
`default_nettype none
module ors_device (
	input wire logic mclk, // System clock
	input wire logic nrst, // Async reset, low
	ors_link_if.device link, // Pins from the host
	output logic ready, // Commands accepted
	output logic displayOn, // Panel display enabled
	output logic [5:0] muxRatio, // Active rows minus one
	output logic segRemap, // Column mapping reversed
	output logic comReverse, // Row scan reversed
	output logic [5:0] startLine, // Display start line
	output logic [6:0] colAddr, // Column address counter
	output ors_pkg::ors_byte_t contrast, // Contrast setting
	output logic allLit, // All pixels lit
	output logic inverse, // Inverted pixel sense
	output logic panelDriven // On and both supplies up
);
	import ors_pkg::*;

	logic inReset; // Reset pin low or no logic supply
	logic selOk; // Straps pick the serial link
	logic rxClear; // Clear the receiver
	logic rxValid; // Byte strobe
	ors_byte_t rxData; // Received byte
	logic rxIsData; // Byte is display data
	ors_dev_state_t state; // Parser state
	ors_dev_state_t next_state;
	logic next_ready;
	logic next_displayOn;
	logic [5:0] next_muxRatio;
	logic next_segRemap;
	logic next_comReverse;
	logic [5:0] next_startLine;
	logic [6:0] next_colAddr;
	ors_byte_t next_contrast;
	logic next_allLit;
	logic next_inverse;
	logic next_panelDriven;

	// An unpowered logic side behaves like a held reset pin
	assign inReset = !link.resetPinLowActive || !link.logicSupplyEn;
	assign selOk = {link.interfaceSelectBit2, link.interfaceSelectBit1,
		link.interfaceSelectBit0} == `ORS_SEL_SPI4;
	// Other interface selections are not built, so bytes are ignored
	assign rxClear = inReset || !selOk;

	// Serial byte receiver
	ors_serial_rx u_rx (
		.mclk(mclk),
		.nrst(nrst),
		.clear(rxClear),
		.csN(link.csN),
		.sclk(link.sclk),
		.sdin(link.sdin),
		.dcN(link.dcN),
		.byteValid(rxValid),
		.byteData(rxData),
		.byteIsData(rxIsData)
	);

	// Next display state from reset pin and received bytes
	always_comb begin
		next_state = state;
		next_ready = ready;
		next_displayOn = displayOn;
		next_muxRatio = muxRatio;
		next_segRemap = segRemap;
		next_comReverse = comReverse;
		next_startLine = startLine;
		next_colAddr = colAddr;
		next_contrast = contrast;
		next_allLit = allLit;
		next_inverse = inverse;
		next_panelDriven = displayOn && link.panelSupplyEn &&
			link.boosterSupplyEn;
		if (inReset) begin
			next_state = D_HOLD;
			next_ready = 1'b0;
			next_displayOn = 1'b0;
			next_muxRatio = `ORS_RST_MUX;
			next_segRemap = 1'b0;
			next_startLine = `ORS_RST_START;
			next_colAddr = `ORS_RST_COL;
			next_comReverse = 1'b0;
			next_contrast = `ORS_RST_CONTRAST;
			next_allLit = 1'b0;
			next_inverse = 1'b0;
			next_panelDriven = 1'b0;
		end else begin
			case (state)
				D_HOLD: begin
					// One cycle after release before bytes count
					next_state = D_IDLE;
					next_ready = 1'b1;
				end
				D_IDLE: begin
					if (rxValid && rxIsData) begin
						// Data byte advances the column, wraps at end
						next_colAddr = colAddr + 7'h01;
					end else if (rxValid) begin
						case (rxData)
							`ORS_CMD_DISP_OFF: next_displayOn = 1'b0;
							`ORS_CMD_DISP_ON: next_displayOn = 1'b1;
							`ORS_CMD_SHOW_RAM: next_allLit = 1'b0;
							`ORS_CMD_ALL_LIT: next_allLit = 1'b1;
							`ORS_CMD_NORMAL: next_inverse = 1'b0;
							`ORS_CMD_INVERSE: next_inverse = 1'b1;
							`ORS_CMD_SEG_NORM: next_segRemap = 1'b0;
							`ORS_CMD_SEG_REMAP: next_segRemap = 1'b1;
							`ORS_CMD_COM_NORM: next_comReverse = 1'b0;
							`ORS_CMD_COM_REV: next_comReverse = 1'b1;
							`ORS_CMD_CONTRAST: next_state = D_ARG_CONTRAST;
							`ORS_CMD_MUX: next_state = D_ARG_MUX;
							default: begin
								// Ranged commands carry their value
								if (rxData[7:6] == 2'h1) begin
									next_startLine = rxData[5:0];
								end else if (rxData[7:4] == 4'h0) begin
									next_colAddr[3:0] = rxData[3:0];
								end else if (rxData[7:4] == 4'h1) begin
									next_colAddr[6:4] = rxData[2:0];
								end
							end
						endcase
					end
				end
				D_ARG_CONTRAST: begin
					// Second byte is the contrast value
					if (rxValid) begin
						next_contrast = rxData;
						next_state = D_IDLE;
					end
				end
				D_ARG_MUX: begin
					if (rxValid) begin
						// Too few rows is ignored, old ratio kept
						if (rxData[5:0] >= `ORS_MUX_MIN) begin
							next_muxRatio = rxData[5:0];
						end
						next_state = D_IDLE;
					end
				end
				default: begin
					next_state = D_HOLD;
					next_ready = 1'b0;
				end
			endcase
		end
	end

	// State registers, reset values match the held reset pin
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= D_HOLD;
			ready <= 1'b0;
			displayOn <= 1'b0;
			muxRatio <= `ORS_RST_MUX;
			segRemap <= 1'b0;
			comReverse <= 1'b0;
			startLine <= `ORS_RST_START;
			colAddr <= `ORS_RST_COL;
			contrast <= `ORS_RST_CONTRAST;
			allLit <= 1'b0;
			inverse <= 1'b0;
			panelDriven <= 1'b0;
		end else begin
			state <= next_state;
			ready <= next_ready;
			displayOn <= next_displayOn;
			muxRatio <= next_muxRatio;
			segRemap <= next_segRemap;
			comReverse <= next_comReverse;
			startLine <= next_startLine;
			colAddr <= next_colAddr;
			contrast <= next_contrast;
			allLit <= next_allLit;
			inverse <= next_inverse;
			panelDriven <= next_panelDriven;
		end
	end
endmodule
`default_nettype wire

// ==== verif/ors_link_checker.sv ====
/*
 Assertion checker on the host-to-display link and display state.
 Assumes one mclk domain and SETTLE equal to the host instance's.
*/
`timescale 1ns/100ps
`default_nettype none
module ors_link_checker #(
	parameter int SETTLE = 50 // Panel settle wait in cycles
) (
	input wire logic mclk, // System clock
	input wire logic nrst, // Async reset, low
	input wire logic resetPinLowActive, // Display reset pin
	input wire logic logicSupplyEn, // Logic supply
	input wire logic boosterSupplyEn, // Booster supply
	input wire logic panelSupplyEn, // Panel supply
	input wire logic interfaceSelectBit0, // Strap bit 0
	input wire logic interfaceSelectBit1, // Strap bit 1
	input wire logic interfaceSelectBit2, // Strap bit 2
	input wire logic csN, // Chip select
	input wire logic ready, // Commands accepted
	input wire logic displayOn, // Display enabled
	input wire logic [5:0] muxRatio, // Rows minus one
	input wire logic segRemap, // Column mapping
	input wire logic comReverse, // Row scan direction
	input wire logic [5:0] startLine, // Start line
	input wire logic [6:0] colAddr, // Column counter
	input wire ors_pkg::ors_byte_t contrast, // Contrast
	input wire logic allLit // All pixels lit
);
	import ors_pkg::*;
	logic [15:0] onCnt, offCnt; // Cycles panel on, off
	logic [15:0] next_onCnt, next_offCnt; // Next counts

	// Saturating panel on and off time, for the settle waits
	always_comb begin
		next_onCnt = !panelSupplyEn ? 16'h0000 :
			(&onCnt ? onCnt : onCnt + 16'h0001);
		next_offCnt = panelSupplyEn ? 16'h0000 :
			(&offCnt ? offCnt : offCnt + 16'h0001);
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			onCnt <= 16'h0000;
			offCnt <= 16'h0000;
		end else begin
			onCnt <= next_onCnt;
			offCnt <= next_offCnt;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	disp_reset_a: assert property (!resetPinLowActive |=>
		!displayOn && muxRatio == 6'h3f)
		else $error("display not off in full mode under reset");
	map_reset_a: assert property (!resetPinLowActive |=> !segRemap)
		else $error("column mapping not normal under reset");
	start_col_a: assert property (!resetPinLowActive |=>
		startLine == 6'h00 && colAddr == 7'h00)
		else $error("start line or column not zero under reset");
	scan_dir_a: assert property (!resetPinLowActive |=> !comReverse)
		else $error("row scan reversed under reset");
	contrast_rst_a: assert property (!resetPinLowActive |=>
		contrast == 8'h7f && !allLit)
		else $error("contrast or display mode wrong under reset");
	ready_hold_a: assert property (!resetPinLowActive |=> !ready)
		else $error("commands accepted while reset low");
	ready_late_a: assert property ($rose(ready) |->
		resetPinLowActive && $past(resetPinLowActive))
		else $error("ready rose too soon after reset");
	cs_order_a: assert property (!csN |->
		resetPinLowActive && logicSupplyEn)
		else $error("byte sent without logic supply or in reset");
	on_settle_a: assert property ($rose(displayOn) |->
		onCnt >= 16'(SETTLE))
		else $error("display on before panel settled");
	off_settle_a: assert property ($fell(logicSupplyEn) |->
		!boosterSupplyEn && offCnt >= 16'(SETTLE))
		else $error("logic supply dropped before discharge");
	panel_logic_a: assert property (panelSupplyEn |-> logicSupplyEn)
		else $error("panel supply on without logic supply");
	strap_code_a: assert property (!csN |->
		{interfaceSelectBit2, interfaceSelectBit1, interfaceSelectBit0} == 3'h0)
		else $error("straps not serial during a byte");

	c_disp_on: cover property ($rose(displayOn));
	c_logic_off: cover property ($fell(logicSupplyEn));
	c_ready: cover property ($rose(ready));
endmodule
`default_nettype wire

// ==== verif/oled_reset_power_sequence_test.sv ====
/*
 Bench: host and display face each other; a second display is driven
 by the bench alone.
 Assumes a 40 MHz mclk and a shortened panel settle wait.
*/
`timescale 1ns/100ps
`default_nettype none
module oled_reset_power_sequence_test;
	import ors_pkg::*;
	logic mclk, nrst, powerUp, powerDown, recover; // Clock, reset, pulses
	logic busy, running, ready, displayOn, segRemap, comReverse, allLit;
	logic [5:0] muxRatio, startLine; // Display state
	logic [6:0] colAddr; // Column counter
	ors_byte_t contrast; // Contrast
	logic readyB, segRemapB, comReverseB, allLitB; // Second display
	logic [5:0] muxRatioB, startLineB; // Second display
	logic [6:0] colAddrB; // Second display
	ors_byte_t contrastB; // Second display
	int num_errors, num_checks; // Mismatches, comparisons

	ors_link_if ors_link_if_i();
	ors_link_if ors_link_if_b_i(); // Driven by the bench
	ors_host #(.SETTLE_CYCLES(50)) ors_host_i (.mclk(mclk), .nrst(nrst),
		.link(ors_link_if_i), .powerUp(powerUp), .powerDown(powerDown),
		.recover(recover), .busy(busy), .running(running));
	ors_device ors_device_i (.mclk(mclk), .nrst(nrst), .link(ors_link_if_i),
		.ready(ready), .displayOn(displayOn), .muxRatio(muxRatio),
		.segRemap(segRemap), .comReverse(comReverse), .startLine(startLine),
		.colAddr(colAddr), .contrast(contrast), .allLit(allLit),
		.inverse(), .panelDriven());
	ors_device ors_device_b_i (.mclk(mclk), .nrst(nrst),
		.link(ors_link_if_b_i), .ready(readyB), .displayOn(),
		.muxRatio(muxRatioB), .segRemap(segRemapB), .comReverse(comReverseB),
		.startLine(startLineB), .colAddr(colAddrB), .contrast(contrastB),
		.allLit(allLitB), .inverse(), .panelDriven());
	ors_link_checker #(.SETTLE(50)) ors_link_checker_i (.mclk(mclk),
		.nrst(nrst), .resetPinLowActive(ors_link_if_i.resetPinLowActive),
		.logicSupplyEn(ors_link_if_i.logicSupplyEn),
		.boosterSupplyEn(ors_link_if_i.boosterSupplyEn),
		.panelSupplyEn(ors_link_if_i.panelSupplyEn),
		.interfaceSelectBit0(ors_link_if_i.interfaceSelectBit0),
		.interfaceSelectBit1(ors_link_if_i.interfaceSelectBit1),
		.interfaceSelectBit2(ors_link_if_i.interfaceSelectBit2),
		.csN(ors_link_if_i.csN), .ready(ready), .displayOn(displayOn),
		.muxRatio(muxRatio), .segRemap(segRemap), .comReverse(comReverse),
		.startLine(startLine), .colAddr(colAddr), .contrast(contrast),
		.allLit(allLit));

	// Compare and count; four-state compare, an unknown matches only an unknown
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("errors=%0d checks=%0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// One pulse on a host request line
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask

	// Bounded wait for the running flag
	task automatic wait_run(input logic v);
		int n;
		n = 0;
		while (running !== v && n < 40000) begin
			cyc(1);
			n++;
		end
		chk({7'h00, running}, {7'h00, v});
	endtask

	// First n bits of a byte, msb first; cs left low if keep
	task automatic send_b(input ors_byte_t b, input logic dc, input int n,
		input logic keep);
		ors_link_if_b_i.csN = 1'b0;
		ors_link_if_b_i.dcN = dc;
		for (int i = 0; i < n; i++) begin
			ors_link_if_b_i.sclk = 1'b0;
			ors_link_if_b_i.sdin = b[7 - i];
			cyc(2);
			ors_link_if_b_i.sclk = 1'b1;
			cyc(2);
		end
		ors_link_if_b_i.sclk = 1'b0;
		ors_link_if_b_i.sdin = ~ors_link_if_b_i.sdin; // Released: no stale bit
		ors_link_if_b_i.csN = !keep;
		cyc(2);
	endtask

	// Requests outside their states are ignored
	task automatic refuse_test();
		pulse(powerDown);
		pulse(recover);
		cyc(2);
		chk({6'h00, busy, ors_link_if_i.logicSupplyEn}, 8'h00);
	endtask

	// Second display: bytes in reset, state restore, shift clear
	task automatic dev_test();
		send_b(8'h41, 1'b0, 8, 1'b0);
		cyc(3);
		chk({1'b0, readyB, startLineB}, 8'h00);
		ors_link_if_b_i.resetPinLowActive = 1'b1;
		cyc(4);
		chk({7'h00, readyB}, 8'h01);
		send_b(8'h41, 1'b0, 8, 1'b0);
		send_b(8'ha1, 1'b0, 8, 1'b0);
		send_b(8'hc8, 1'b0, 8, 1'b0);
		send_b(8'ha5, 1'b0, 8, 1'b0);
		send_b(8'ha8, 1'b0, 8, 1'b0);
		send_b(8'h1f, 1'b0, 8, 1'b0);
		send_b(8'h81, 1'b0, 8, 1'b0);
		send_b(8'h20, 1'b0, 8, 1'b0);
		send_b(8'h55, 1'b1, 8, 1'b0);
		cyc(3);
		chk({segRemapB, comReverseB, allLitB, 5'h00}, 8'he0);
		chk({1'b1, colAddrB}, 8'h81);
		chk({startLineB, muxRatioB[1:0]}, 8'h07);
		chk(contrastB, 8'h20);
		send_b(8'hff, 1'b0, 4, 1'b1);
		ors_link_if_b_i.resetPinLowActive = 1'b0;
		cyc(3);
		chk({2'h0, muxRatioB}, 8'h3f);
		chk({segRemapB, comReverseB, allLitB, 5'h00}, 8'h00);
		chk({1'b0, colAddrB}, 8'h00);
		chk({1'b0, readyB, startLineB}, 8'h00);
		chk(contrastB, 8'h7f);
		ors_link_if_b_i.resetPinLowActive = 1'b1;
		cyc(4);
		send_b(8'h81, 1'b0, 8, 1'b0);
		send_b(8'h33, 1'b0, 8, 1'b0);
		cyc(3);
		chk(contrastB, 8'h33);
	endtask

	// Host power-up against the real display
	task automatic power_up_test();
		pulse(powerUp);
		cyc(2);
		chk({busy, ors_link_if_i.logicSupplyEn,
			ors_link_if_i.panelSupplyEn, displayOn, 4'h0}, 8'hc0);
		wait_run(1'b1);
		cyc(4);
		chk({displayOn, segRemap, comReverse, allLit, ready, 3'h0}, 8'h88);
		chk({1'b0, colAddr}, 8'h00);
		chk(contrast, 8'h7f);
	endtask

	// Noise recovery: reset pulse, then back to running
	task automatic recover_test();
		int n;
		pulse(recover);
		n = 0;
		while (ors_link_if_i.resetPinLowActive !== 1'b0 && n < 10) begin
			cyc(1);
			n++;
		end
		cyc(3);
		chk({displayOn, ready, startLine}, 8'h00);
		wait_run(1'b1);
		cyc(4);
		chk({7'h00, displayOn}, 8'h01);
	endtask

	task automatic power_down_test();
		pulse(powerDown);
		cyc(2);
		chk({6'h00, busy, running}, 8'h02);
		wait_run(1'b0);
		cyc(200);
		chk({5'h00, busy, ors_link_if_i.logicSupplyEn,
			displayOn}, 8'h00);
	endtask

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		#2500000;
		num_errors++;
		stop_test();
	end

	initial begin
		num_errors = 0;
		num_checks = 0;
		nrst = 1'b0;
		{powerUp, powerDown, recover} = 3'h0;
		ors_link_if_b_i.resetPinLowActive = 1'b0;
		{ors_link_if_b_i.logicSupplyEn, ors_link_if_b_i.boosterSupplyEn} = 2'h3;
		ors_link_if_b_i.panelSupplyEn = 1'b0;
		ors_link_if_b_i.interfaceSelectBit0 = 1'b0;
		ors_link_if_b_i.interfaceSelectBit1 = 1'b0;
		ors_link_if_b_i.interfaceSelectBit2 = 1'b0;
		{ors_link_if_b_i.csN, ors_link_if_b_i.dcN} = 2'h2;
		{ors_link_if_b_i.sclk, ors_link_if_b_i.sdin} = 2'h0;
		cyc(6);
		nrst = 1'b1;
		refuse_test();
		dev_test();
		power_up_test();
		recover_test();
		power_down_test();
		stop_test();
	end
endmodule
`default_nettype wire
